// file: testbench/psc_checker.sv
// assertion checker for the partition state control block
`timescale 1ns/1ps
`default_nettype none
module psc_checker #(
	parameter int NPART = 16,
	parameter int NPORT = 16
) (
	input wire logic                  clk,
	input wire logic                  arst_n,
	input wire logic                  psel,
	input wire logic                  penable,
	input wire logic                  pwrite,
	input wire logic [11:0]           paddr,
	input wire logic [31:0]           pwdata,
	input wire logic [31:0]           prdata,
	input wire logic                  pready,
	input wire logic                  pslverr,
	input wire logic [NPART-1:0]      partition_reset_pin_n,
	input wire logic [NPORT-1:0][1:0] port_eff_mode,
	input wire logic [NPORT-1:0]      port_in_reset,
	input wire logic [NPART-1:0]      part_reset,
	input wire logic [NPART-1:0]      part_up_only,
	input wire logic [NPART-1:0]      part_no_up,
	input wire logic [NPART-1:0]      part_link_down_reset_disable
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!arst_n);

	// ************************************************************
	// bus answer
	// ************************************************************
	pready_one_a: assert property (pready |=> !pready)
		else $error("pready stood longer than one cycle");
	pready_cause_a: assert property (pready |-> psel && penable && $past(psel && !penable))
		else $error("pready without a preceding setup");
	setup_ans_a: assert property (psel && !penable |=> pready)
		else $error("setup not answered in first access cycle");
	rdata_idle_a: assert property (!pready |-> prdata == 32'h0)
		else $error("read data not zero outside answer");
	slverr_pair_a: assert property (pslverr |-> pready)
		else $error("error flag without pready");
	// upper three quarters of the space hold nothing
	unmapped_err_a: assert property (psel && !penable && paddr[11:10] != 2'h0 |=> pslverr)
		else $error("unmapped access not flagged");
	mapped_ok_a: assert property (psel && !penable && paddr[11:6] == 6'h0 &&
		paddr[1:0] == 2'h0 |=> !pslverr)
		else $error("port control access flagged");

	// ************************************************************
	// partition shape
	// ************************************************************
	cfg_excl_a: assert property ((part_up_only & part_no_up) == '0)
		else $error("partition both upstream-only and without upstream");
	unatt_free_a: assert property (port_eff_mode[1] == psc_pkg::MODE_UNATT &&
		$past(port_eff_mode[1]) == psc_pkg::MODE_UNATT |-> !port_in_reset[1])
		else $error("unattached port follows a partition reset");

	cover property (pslverr);
	cover property ($rose(part_reset[1]));
	cover property ($rose(part_up_only[1]));
	cover property ($rose(part_no_up[1]));
endmodule

bind psc_top psc_checker #(.NPART(NPART), .NPORT(NPORT)) chk (
	.clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.partition_reset_pin_n(partition_reset_pin_n), .port_eff_mode(port_eff_mode),
	.port_in_reset(port_in_reset), .part_reset(part_reset), .part_up_only(part_up_only),
	.part_no_up(part_no_up), .part_link_down_reset_disable(part_link_down_reset_disable)
);
`default_nettype wire

// file: testbench/test_switch_partition_state_control.sv
// self-checking bench for the partition state control block
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin n_fail++; \
	$display("unexpected at %0t: got %h expected %h", $time, (a), (b)); end end
module test_switch_partition_state_control;
	typedef struct {logic w; logic [11:0] a; logic [31:0] d; logic [31:0] e;} psc_row_t;
	logic             clk, arst_n, psel, penable, pwrite, pready, pslverr;
	logic [11:0]      paddr;
	logic [31:0]      pwdata, prdata, rd;
	logic [15:0]      pin_n, prst, up_only, no_up, lddis;
	logic [15:0][1:0] eff;
	logic [15:0]      port_rst;
	logic             err;
	int               n_fail, num_checks, k;
	psc_row_t         rows [10];

	psc_top uut (.clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.partition_reset_pin_n(pin_n), .port_eff_mode(eff), .port_in_reset(port_rst),
		.part_reset(prst), .part_up_only(up_only), .part_no_up(no_up),
		.part_link_down_reset_disable(lddis));

	initial begin
		clk = 0;
		forever #50 clk = ~clk;
	end

	task automatic end_sim();
		$display("checks %0d failures %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// ************************************************************
	// bus master
	// ************************************************************
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n >= 20) begin
			n_fail++;
			end_sim();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0; penable <= 1'b0;
		@(posedge clk);
	endtask

	// poll change_done of a partition, bounded
	task automatic wait_done(input logic [11:0] sa);
		k = 0;
		do begin
			apb(1'b0, sa, 32'h0);
			k++;
		end while (rd[1] !== 1'b1 && k < 200);
		if (k >= 200) begin
			n_fail++;
			end_sim();
		end
	endtask

	initial begin
		psel = 0; penable = 0; pwrite = 0; paddr = 12'h0; pwdata = 32'h0;
		pin_n = 16'hffff; arst_n = 0; n_fail = 0; num_checks = 0;
		// reset drain timer shortened so the reset drain wait stays short
		rows = '{'{0, 12'h300, 0, 32'h4}, '{0, 12'h304, 0, 32'h8}, '{0, 12'h308, 0, 32'h9c4},
			'{0, 12'h30c, 0, 32'h10}, '{0, 12'h204, 0, 32'h0}, '{1, 12'h300, 0, 32'h0},
			'{1, 12'h00c, 32'h12, 32'h12}, '{1, 12'h004, 32'h13, 32'h13},
			'{1, 12'h308, 32'h14, 32'h14}, '{0, 12'h104, 0, 32'h0}};
		repeat (10) @(posedge clk);
		arst_n <= 1'b1;
		@(posedge clk);
		foreach (rows[i]) begin
			if (rows[i].w)
				apb(1'b1, rows[i].a, rows[i].d);
			apb(1'b0, rows[i].a, 32'h0);
			`CHK(rd, rows[i].e)
		end
		// ************************************************************
		// partition 1: up port 3, down port 1, still disabled
		// ************************************************************
		`CHK(eff[3], psc_pkg::MODE_DIS)
		apb(1'b0, 12'h204, 32'h0);
		`CHK(rd, 32'h34)
		apb(1'b1, 12'h104, 32'h6);
		apb(1'b0, 12'h204, 32'h0);
		`CHK(rd[1:0], 2'h1)
		wait_done(12'h204);
		`CHK(rd[9:8], psc_pkg::ST_ACT)
		`CHK({eff[3], eff[1]}, {psc_pkg::MODE_UP, psc_pkg::MODE_DN})
		`CHK({up_only[1], no_up[1], lddis[1]}, 3'b001)
		apb(1'b1, 12'h204, 32'h3);
		apb(1'b0, 12'h204, 32'h0);
		`CHK(rd, 32'h234)
		// ************************************************************
		// reset entry: drain wait, held, flag cleared
		// ************************************************************
		apb(1'b1, 12'h104, 32'h1);
		apb(1'b0, 12'h204, 32'h0);
		`CHK(rd[1:0], 2'h1)
		repeat (10) @(posedge clk);
		apb(1'b0, 12'h204, 32'h0);
		`CHK(rd[1], 1'b0)
		wait_done(12'h204);
		repeat (20) @(posedge clk);
		`CHK({prst[1], port_rst[3], lddis[1]}, 3'b110)
		// reserved code leaves state and flags alone
		apb(1'b1, 12'h204, 32'h3);
		apb(1'b1, 12'h104, 32'h3);
		apb(1'b0, 12'h204, 32'h0);
		`CHK(rd[9:0], 10'h134)
		// ************************************************************
		// reset pin holds back completion to active
		// ************************************************************
		pin_n[1] <= 1'b0;
		repeat (8) @(posedge clk);
		apb(1'b1, 12'h104, 32'h2);
		repeat (40) @(posedge clk);
		apb(1'b0, 12'h204, 32'h0);
		`CHK(rd[1:0], 2'h1)
		`CHK(prst[1], 1'b1)
		pin_n[1] <= 1'b1;
		wait_done(12'h204);
		`CHK(rd[9:8], psc_pkg::ST_ACT)
		// ************************************************************
		// partition shapes and unattached ports
		// ************************************************************
		apb(1'b1, 12'h004, 32'h11);
		repeat (3) @(posedge clk);
		`CHK({up_only[1], no_up[1], eff[1], port_rst[1]}, 5'b10010)
		apb(1'b1, 12'h00c, 32'h11);
		apb(1'b1, 12'h004, 32'h13);
		apb(1'b0, 12'h204, 32'h0);
		`CHK({up_only[1], no_up[1]}, 2'b01)
		`CHK(rd & 32'h3f4, 32'h200)
		// empty partition 2 has no effect in reset
		apb(1'b1, 12'h108, 32'h1);
		wait_done(12'h208);
		`CHK({prst[2], rd[9:8]}, 3'b001)
		// unmapped place: flagged, reads zero, write dropped
		apb(1'b1, 12'h400, 32'h5);
		apb(1'b0, 12'h400, 32'h0);
		`CHK({err, rd}, 33'h100000000)
		// ************************************************************
		// second reset in mid-run
		// ************************************************************
		arst_n <= 1'b0;
		repeat (2) @(posedge clk);
		arst_n <= 1'b1;
		@(posedge clk);
		`CHK({prst, eff}, 48'h0)
		apb(1'b0, 12'h204, 32'h0);
		`CHK(rd, 32'h0)
		apb(1'b0, 12'h300, 32'h0);
		`CHK(rd, 32'h4)
		end_sim();
	end
endmodule
`default_nettype wire

// file: verilog/psc_chg_fsm.sv
// per-partition state change sequencer: delay count and pin hold
`timescale 1ns/1ps
`default_nettype none
module psc_chg_fsm (
	input  wire logic        clk,
	input  wire logic        arst_n,
	input  wire logic        start,
	input  wire logic [16:0] delay,
	input  wire logic        need_pin_clear,
	input  wire logic        pin_held,
	output logic             busy,
	output logic             done_pulse
);
	psc_pkg::psc_chg_t st_ff, nxt_st;
	logic [16:0] cnt_ff, nxt_cnt;
	logic        need_ff, nxt_need;
	logic        done_ff, nxt_done;

	always_comb begin
		nxt_st   = st_ff;
		nxt_cnt  = cnt_ff;
		nxt_need = need_ff;
		nxt_done = 1'b0;
		if (start) begin
			// a new request restarts the count
			nxt_st   = psc_pkg::CHG_COUNT;
			nxt_cnt  = delay;
			nxt_need = need_pin_clear;
		end else begin
			unique case (st_ff)
				psc_pkg::CHG_IDLE: begin
				end
				psc_pkg::CHG_COUNT: begin
					if (cnt_ff != 17'h0) begin
						nxt_cnt = cnt_ff - 17'h1;
					end else if (need_ff && pin_held) begin
						nxt_st = psc_pkg::CHG_HOLD;
					end else begin
						nxt_st   = psc_pkg::CHG_IDLE;
						nxt_done = 1'b1;
					end
				end
				psc_pkg::CHG_HOLD: begin
					if (!pin_held) begin
						nxt_st   = psc_pkg::CHG_IDLE;
						nxt_done = 1'b1;
					end
				end
				default: begin
					nxt_st = psc_pkg::CHG_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			st_ff   <= psc_pkg::CHG_IDLE;
			cnt_ff  <= 17'h0;
			need_ff <= 1'b0;
			done_ff <= 1'b0;
		end else begin
			st_ff   <= nxt_st;
			cnt_ff  <= nxt_cnt;
			need_ff <= nxt_need;
			done_ff <= nxt_done;
		end
	end

	assign busy       = (st_ff != psc_pkg::CHG_IDLE);
	assign done_pulse = done_ff;
endmodule
`default_nettype wire

// file: verilog/psc_pkg.sv
// shared constants and types for the switch partition state control block
package psc_pkg;

	// ************************************************************
	// sizes
	// ************************************************************
	localparam int NUM_PART = 16;
	localparam int NUM_PORT = 16;
	localparam int TMR_W    = 16;

	// ************************************************************
	// register map, region numbers (paddr[11:8]) and timer indices
	// ************************************************************
	localparam logic [3:0] REG_PORT_CTL = 4'h0;
	localparam logic [3:0] REG_PART_CTL = 4'h1;
	localparam logic [3:0] REG_PART_STS = 4'h2;
	localparam logic [3:0] REG_TIMER    = 4'h3;
	localparam logic [3:0] TMR_SIDE_EFFECT = 4'h0;
	localparam logic [3:0] TMR_MODE_DRAIN  = 4'h1;
	localparam logic [3:0] TMR_RESET_DRAIN = 4'h2;
	localparam logic [3:0] TMR_UP_BRIDGE   = 4'h3;

	// ************************************************************
	// field positions
	// ************************************************************
	localparam int PCTL_MODE_LSB = 0;
	localparam int PCTL_PART_LSB = 4;
	localparam int PART_STATE_LSB = 0;
	localparam int PART_LDRD_BIT  = 2;
	localparam int STS_STARTED_BIT = 0;
	localparam int STS_DONE_BIT    = 1;
	localparam int STS_UP_BIT      = 2;
	localparam int STS_UPID_LSB    = 4;
	localparam int STS_STATE_LSB   = 8;

	// ************************************************************
	// encodings
	// ************************************************************
	localparam logic [1:0] MODE_DIS   = 2'h0;
	localparam logic [1:0] MODE_UNATT = 2'h1;
	localparam logic [1:0] MODE_UP    = 2'h2;
	localparam logic [1:0] MODE_DN    = 2'h3;
	localparam logic [1:0] ST_DIS  = 2'h0;
	localparam logic [1:0] ST_FRST = 2'h1;
	localparam logic [1:0] ST_ACT  = 2'h2;
	localparam logic [1:0] ST_RSVD = 2'h3;

	// ************************************************************
	// reset values and timing
	// ************************************************************
	localparam logic [1:0] RST_PORT_MODE  = MODE_DIS;
	localparam logic [1:0] RST_PART_STATE = ST_DIS;
	localparam int CLK_KHZ      = 10000;
	localparam int RDRAIN_USEC  = 250;
	localparam int RDRAIN_CYC   = (RDRAIN_USEC * CLK_KHZ + 999) / 1000;
	localparam logic [TMR_W-1:0] RST_SIDE_EFFECT = 16'h0004;
	localparam logic [TMR_W-1:0] RST_MODE_DRAIN  = 16'h0008;
	localparam logic [TMR_W-1:0] RST_RESET_DRAIN = TMR_W'(RDRAIN_CYC);
	localparam logic [TMR_W-1:0] RST_UP_BRIDGE   = 16'h0010;

	typedef enum logic [2:0] {
		CHG_IDLE  = 3'b001,
		CHG_COUNT = 3'b010,
		CHG_HOLD  = 3'b100
	} psc_chg_t;

endpackage

// file: verilog/psc_sync.sv
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module psc_sync #(
	parameter int W = 16
) (
	input  wire logic         clk,
	input  wire logic         arst_n,
	input  wire logic [W-1:0] din,
	output logic      [W-1:0] dout
);
	logic [W-1:0] s1_ff, s2_ff, s3_ff, filt_ff;
	logic [W-1:0] nxt_filt;

	// a bit only moves once stages two and three agree
	always_comb begin
		nxt_filt = (s2_ff & s3_ff) | (filt_ff & (s2_ff ^ s3_ff));
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			s1_ff   <= '1;
			s2_ff   <= '1;
			s3_ff   <= '1;
			filt_ff <= '1;
		end else begin
			s1_ff   <= din;
			s2_ff   <= s1_ff;
			s3_ff   <= s2_ff;
			filt_ff <= nxt_filt;
		end
	end

	assign dout = filt_ff;
endmodule
`default_nettype wire

// file: verilog/psc_top.sv
// switch partition state control with apb register slave
//
// The implementer's own choices: the placing of the registers and register access over APB.
`timescale 1ns/1ps
`default_nettype none
module psc_top #(
	parameter int NPART = psc_pkg::NUM_PART,
	parameter int NPORT = psc_pkg::NUM_PORT
) (
	input  wire logic                   clk,
	input  wire logic                   arst_n,
	input  wire logic                   psel,
	input  wire logic                   penable,
	input  wire logic                   pwrite,
	input  wire logic [11:0]            paddr,
	input  wire logic [31:0]            pwdata,
	output logic      [31:0]            prdata,
	output logic                        pready,
	output logic                        pslverr,
	input  wire logic [NPART-1:0]       partition_reset_pin_n,
	output logic      [NPORT-1:0][1:0]  port_eff_mode,
	output logic      [NPORT-1:0]       port_in_reset,
	output logic      [NPART-1:0]       part_reset,
	output logic      [NPART-1:0]       part_up_only,
	output logic      [NPART-1:0]       part_no_up,
	output logic      [NPART-1:0]       part_link_down_reset_disable
);
	// ************************************************************
	// state
	// ************************************************************
	logic [NPORT-1:0][1:0] port_mode_ff, nxt_port_mode;
	logic [NPORT-1:0][3:0] port_part_ff, nxt_port_part;
	logic [NPART-1:0][1:0] part_state_ff, nxt_part_state;
	logic [NPART-1:0]      ldrd_ff, nxt_ldrd;
	logic [NPART-1:0]      started_ff, nxt_started;
	logic [NPART-1:0]      done_ff, nxt_done;
	logic [3:0][psc_pkg::TMR_W-1:0] tmr_ff, nxt_tmr;
	logic [31:0] prdata_ff, nxt_prdata;
	logic        pready_ff, nxt_pready;
	logic        pslverr_ff, nxt_pslverr;
	logic [NPORT-1:0][1:0] eff_mode_ff, nxt_eff_mode;
	logic [NPORT-1:0]      port_rst_ff, nxt_port_rst;
	logic [NPART-1:0]      part_rst_ff, nxt_part_rst;
	logic [NPART-1:0]      up_only_ff, nxt_up_only;
	logic [NPART-1:0]      no_up_ff, nxt_no_up;

	logic [NPART-1:0]      pin_sync, pin_held, done_pulse, start;
	logic [NPART-1:0]      up_present, has_dn, has_port;
	logic [NPART-1:0][3:0] up_id;
	logic [16:0] delay;
	logic        need_pin;
	logic        wr_en, setup, in_range;
	logic [3:0]  region, idx;
	logic [1:0]  wstate;

	assign region = paddr[11:8];
	assign idx    = paddr[5:2];
	assign wstate = pwdata[psc_pkg::PART_STATE_LSB +: 2];
	assign setup  = psel && !penable;
	// the write lands on the edge where the master sees pready high
	assign wr_en  = psel && penable && pready_ff && pwrite && !pslverr_ff;

	// ************************************************************
	// reset pin synchroniser
	// ************************************************************
	psc_sync #(.W(NPART)) u_sync (
		.clk    (clk),
		.arst_n (arst_n),
		.din    (partition_reset_pin_n),
		.dout   (pin_sync)
	);
	assign pin_held = ~pin_sync;

	// ************************************************************
	// membership
	// ************************************************************
	always_comb begin
		up_present = '0;
		has_dn     = '0;
		up_id      = '0;
		for (int p = 0; p < NPART; p++) begin
			for (int i = 0; i < NPORT; i++) begin
				if (int'(port_part_ff[i]) == p) begin
					if (port_mode_ff[i] == psc_pkg::MODE_UP) begin
						up_present[p] = 1'b1;
						up_id[p]      = 4'(i);
					end
					if (port_mode_ff[i] == psc_pkg::MODE_DN) begin
						has_dn[p] = 1'b1;
					end
				end
			end
		end
		has_port = up_present | has_dn;
	end

	// ************************************************************
	// change delay for the addressed partition
	// ************************************************************
	always_comb begin
		need_pin = (wstate == psc_pkg::ST_ACT);
		if (wstate == psc_pkg::ST_FRST) begin
			delay = {1'b0, tmr_ff[psc_pkg::TMR_RESET_DRAIN]};
		end else if (has_port[idx] && (wstate == psc_pkg::ST_DIS ||
				part_state_ff[idx] == psc_pkg::ST_DIS)) begin
			// port modes flip too, so wait for their drain as well
			delay = {1'b0, tmr_ff[psc_pkg::TMR_SIDE_EFFECT]}
				+ {1'b0, tmr_ff[psc_pkg::TMR_MODE_DRAIN]};
		end else begin
			delay = {1'b0, tmr_ff[psc_pkg::TMR_SIDE_EFFECT]};
		end
	end

	genvar g;
	generate
		for (g = 0; g < NPART; g++) begin : g_part
			psc_chg_fsm u_fsm (
				.clk            (clk),
				.arst_n         (arst_n),
				.start          (start[g]),
				.delay          (delay),
				.need_pin_clear (need_pin),
				.pin_held       (pin_held[g]),
				.busy           (),
				.done_pulse     (done_pulse[g])
			);
		end
	endgenerate

	// ************************************************************
	// register writes and flags
	// ************************************************************
	always_comb begin
		nxt_port_mode  = port_mode_ff;
		nxt_port_part  = port_part_ff;
		nxt_part_state = part_state_ff;
		nxt_ldrd       = ldrd_ff;
		nxt_tmr        = tmr_ff;
		start          = '0;
		nxt_started    = started_ff;
		nxt_done       = done_ff;
		if (wr_en) begin
			unique case (region)
				psc_pkg::REG_PORT_CTL: begin
					nxt_port_mode[idx] = pwdata[psc_pkg::PCTL_MODE_LSB +: 2];
					nxt_port_part[idx] = pwdata[psc_pkg::PCTL_PART_LSB +: 4];
				end
				psc_pkg::REG_PART_CTL: begin
					nxt_ldrd[idx] = pwdata[psc_pkg::PART_LDRD_BIT];
					// reserved code is refused, same code is no change
					if (wstate != psc_pkg::ST_RSVD && wstate != part_state_ff[idx]) begin
						nxt_part_state[idx] = wstate;
						start[idx] = 1'b1;
					end
					if (wstate == psc_pkg::ST_FRST && part_state_ff[idx] != psc_pkg::ST_FRST) begin
						nxt_ldrd[idx] = 1'b0;
					end
				end
				psc_pkg::REG_PART_STS: begin
					if (pwdata[psc_pkg::STS_STARTED_BIT]) begin
						nxt_started[idx] = 1'b0;
					end
					if (pwdata[psc_pkg::STS_DONE_BIT]) begin
						nxt_done[idx] = 1'b0;
					end
				end
				psc_pkg::REG_TIMER: begin
					nxt_tmr[idx[1:0]] = pwdata[psc_pkg::TMR_W-1:0];
				end
				default: begin
				end
			endcase
		end
		// set beats a simultaneous clear
		for (int p = 0; p < NPART; p++) begin
			if (start[p]) begin
				nxt_started[p] = 1'b1;
				nxt_done[p]    = 1'b0;
			end
			if (done_pulse[p]) begin
				nxt_done[p] = 1'b1;
			end
		end
	end

	// ************************************************************
	// apb read and answer, one access cycle
	// ************************************************************
	always_comb begin
		in_range = paddr[7:6] == 2'h0 && paddr[1:0] == 2'h0 && (
			(region == psc_pkg::REG_PORT_CTL && int'(idx) < NPORT) ||
			((region == psc_pkg::REG_PART_CTL || region == psc_pkg::REG_PART_STS)
				&& int'(idx) < NPART) ||
			(region == psc_pkg::REG_TIMER && idx < 4'h4));
		nxt_prdata  = 32'h0;
		nxt_pready  = setup;
		nxt_pslverr = setup && !in_range;
		if (setup && in_range && !pwrite) begin
			unique case (region)
				psc_pkg::REG_PORT_CTL: begin
					nxt_prdata[psc_pkg::PCTL_MODE_LSB +: 2] = port_mode_ff[idx];
					nxt_prdata[psc_pkg::PCTL_PART_LSB +: 4] = port_part_ff[idx];
				end
				psc_pkg::REG_PART_CTL: begin
					nxt_prdata[psc_pkg::PART_STATE_LSB +: 2] = part_state_ff[idx];
					nxt_prdata[psc_pkg::PART_LDRD_BIT]       = ldrd_ff[idx];
				end
				psc_pkg::REG_PART_STS: begin
					nxt_prdata[psc_pkg::STS_STARTED_BIT]    = started_ff[idx];
					nxt_prdata[psc_pkg::STS_DONE_BIT]       = done_ff[idx];
					nxt_prdata[psc_pkg::STS_UP_BIT]         = up_present[idx];
					// id only meaningful while present
					nxt_prdata[psc_pkg::STS_UPID_LSB +: 4]  =
						up_present[idx] ? up_id[idx] : 4'h0;
					nxt_prdata[psc_pkg::STS_STATE_LSB +: 2] = part_state_ff[idx];
				end
				default: begin
					nxt_prdata[psc_pkg::TMR_W-1:0] = tmr_ff[idx[1:0]];
				end
			endcase
		end
	end

	// ************************************************************
	// partition effects on ports and traffic
	// ************************************************************
	always_comb begin
		for (int p = 0; p < NPART; p++) begin
			// empty partitions drive nothing
			nxt_part_rst[p] = has_port[p] && (part_state_ff[p] == psc_pkg::ST_FRST
				|| pin_held[p]);
			nxt_up_only[p]  = up_present[p] && !has_dn[p];
			nxt_no_up[p]    = !up_present[p] && has_dn[p];
		end
		for (int i = 0; i < NPORT; i++) begin
			nxt_eff_mode[i] = port_mode_ff[i];
			nxt_port_rst[i] = 1'b0;
			if (port_mode_ff[i] == psc_pkg::MODE_UP || port_mode_ff[i] == psc_pkg::MODE_DN) begin
				if (part_state_ff[port_part_ff[i]] == psc_pkg::ST_DIS) begin
					nxt_eff_mode[i] = psc_pkg::MODE_DIS;
				end
				nxt_port_rst[i] = nxt_part_rst[port_part_ff[i]];
			end
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			port_mode_ff  <= {NPORT{psc_pkg::RST_PORT_MODE}};
			port_part_ff  <= '0;
			part_state_ff <= {NPART{psc_pkg::RST_PART_STATE}};
			ldrd_ff       <= '0;
			started_ff    <= '0;
			done_ff       <= '0;
			tmr_ff        <= {psc_pkg::RST_UP_BRIDGE, psc_pkg::RST_RESET_DRAIN,
				psc_pkg::RST_MODE_DRAIN, psc_pkg::RST_SIDE_EFFECT};
			prdata_ff     <= 32'h0;
			pready_ff     <= 1'b0;
			pslverr_ff    <= 1'b0;
			eff_mode_ff   <= {NPORT{psc_pkg::MODE_DIS}};
			port_rst_ff   <= '0;
			part_rst_ff   <= '0;
			up_only_ff    <= '0;
			no_up_ff      <= '0;
		end else begin
			port_mode_ff  <= nxt_port_mode;
			port_part_ff  <= nxt_port_part;
			part_state_ff <= nxt_part_state;
			ldrd_ff       <= nxt_ldrd;
			started_ff    <= nxt_started;
			done_ff       <= nxt_done;
			tmr_ff        <= nxt_tmr;
			prdata_ff     <= nxt_prdata;
			pready_ff     <= nxt_pready;
			pslverr_ff    <= nxt_pslverr;
			eff_mode_ff   <= nxt_eff_mode;
			port_rst_ff   <= nxt_port_rst;
			part_rst_ff   <= nxt_part_rst;
			up_only_ff    <= nxt_up_only;
			no_up_ff      <= nxt_no_up;
		end
	end

	assign prdata        = prdata_ff;
	assign pready        = pready_ff;
	assign pslverr       = pslverr_ff;
	assign port_eff_mode = eff_mode_ff;
	assign port_in_reset = port_rst_ff;
	assign part_reset    = part_rst_ff;
	assign part_up_only  = up_only_ff;
	assign part_no_up    = no_up_ff;
	assign part_link_down_reset_disable = ldrd_ff;
endmodule
`default_nettype wire
